// ===== wsrc_top.sv
`timescale 1ns/10ps
`include "wsrc_map.svh"
// Summary of operation
// - Select code picks wait register; memory/IO picks its nibble.
// - Select code 11 disables wait generation.
// - Three registers; high nibble memory, low IO.
// - Cycle-done output is clock synchronized.
// - Own register accesses also get cycle-done.
// - Ready input sampled to end each cycle.
// - After reset all outputs inactive, slave mode.
// - Software reset or shutdown: 62-clock CPU reset.
// - Otherwise CPU reset follows hardware reset.
// - Chip select during addressed slave cycles.
// - Chip select during driving acknowledge cycles.
// - Pipelining judged from strobe and ready history.
module wsrc_top #(
    parameter logic [5:0] RST_HOLD = `WSRC_PROCESSOR_RESET_OUT_CLKS
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Local bus pins.
    input wire logic address_strobe_n_i,
    input wire logic ready_n_i,
    input wire logic hw_reset_i,
    input wire logic wait_select_bit0_i,
    input wire logic wait_select_bit1_i,
    input wire logic mem_io_i,
    input wire logic write_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] data_i,
    // Internal events from the rest of the peripheral.
    input wire logic sw_reset_cmd_i,
    input wire logic shutdown_detect_i,
    input wire logic inta_drive_i,
    // Outputs.
    output logic cycle_done_out_n_o,
    output logic chip_selected_n_o,
    output logic processor_reset_out_o,
    output logic [7:0] data_o,
    output logic data_oe_o
);

    // ========================================================
    // Own register decode.
    function automatic logic [2:0] wsrc_hit(input logic [7:0] a,
                                           input logic mio);
        logic [2:0] r;
        r = 3'h0;
        if (!mio && a == `WSRC_ADDR_WCS0) begin
            r = {1'b1, `WSRC_IDX_WCS0};
        end else if (!mio && a == `WSRC_ADDR_WCS1) begin
            r = {1'b1, `WSRC_IDX_WCS1};
        end else if (!mio && a == `WSRC_ADDR_WCS2) begin
            r = {1'b1, `WSRC_IDX_WCS2};
        end
        return r;
    endfunction

    // ========================================================
    // State and next state.
    wsrc_pkg::wsrc_regs_t q_ff;
    wsrc_pkg::wsrc_regs_t nxt_q;
    wsrc_pkg::wsrc_pins_t pins;
    wsrc_pkg::wsrc_pins_t p;
    logic [22:0] agree;
    logic start;
    logic trig;
    logic load;
    logic pipe;
    logic [2:0] hit;
    logic [3:0] ws;
    logic [7:0] wsel_reg;

    // Pin captures start at the idle bus levels, so that no false
    // strobe or hardware reset is seen right after release.
    localparam wsrc_pkg::wsrc_pins_t IDLE_PINS = '{
        ads_n: 1'b1, rdy_n: 1'b1, hw_rst: 1'b0, wsel: 2'h0,
        mio: 1'b0, wr: 1'b0, addr: 8'h00, data: 8'h00
    };

    localparam wsrc_pkg::wsrc_regs_t RESET_Q = '{
        s1: IDLE_PINS, s2: IDLE_PINS, s3: IDLE_PINS, filt: IDLE_PINS,
        ads_prev: 1'b1, state: wsrc_pkg::WSRC_IDLE,
        cnt: 6'h00, drv: 1'b0, own: 1'b0, wr: 1'b0,
        idx: 2'h0, pend: 1'b0,
        wcs: {3{`WSRC_WCS_RESET}},
        rst_cnt: 6'h00, done_n: 1'b1, csel_n: 1'b1,
        processor_reset_out: 1'b0, dout: 8'h00, doe: 1'b0
    };

    assign pins = '{
        ads_n: address_strobe_n_i, rdy_n: ready_n_i,
        hw_rst: hw_reset_i,
        wsel: {wait_select_bit1_i, wait_select_bit0_i},
        mio: mem_io_i, wr: write_i, addr: addr_i, data: data_i
    };
    assign p = q_ff.filt;
    assign start = !p.ads_n && q_ff.ads_prev;
    assign trig = sw_reset_cmd_i || shutdown_detect_i;

    always_comb begin
        nxt_q = q_ff;
        // Three-stage capture; a change counts once stages two and
        // three agree.
        nxt_q.s1 = pins;
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        agree = ~(q_ff.s2 ^ q_ff.s3);
        nxt_q.filt = (q_ff.s3 & agree) | (q_ff.filt & ~agree);
        nxt_q.ads_prev = p.ads_n;
        load = 1'b0;
        pipe = 1'b0;
        // A strobe while a cycle is open is a pipelined address.
        if (start && q_ff.state != wsrc_pkg::WSRC_IDLE) begin
            nxt_q.pend = 1'b1;
        end
        unique case (q_ff.state)
            wsrc_pkg::WSRC_IDLE: begin
                load = start;
            end
            wsrc_pkg::WSRC_WAIT: begin
                // A ready still low from the previous cycle must leave
                // the capture first, or it would end this cycle at once.
                if (q_ff.cnt != 6'h00) begin
                    nxt_q.cnt = q_ff.cnt - 6'h01;
                end else if (p.rdy_n) begin
                    nxt_q.state = wsrc_pkg::WSRC_END;
                    nxt_q.done_n = !q_ff.drv;
                end
            end
            wsrc_pkg::WSRC_END: begin
                if (!p.rdy_n) begin
                    nxt_q.done_n = 1'b1;
                    nxt_q.state = wsrc_pkg::WSRC_IDLE;
                    nxt_q.own = 1'b0;
                    nxt_q.doe = 1'b0;
                    if (q_ff.own && q_ff.wr) begin
                        nxt_q.wcs[q_ff.idx] = p.data;
                    end
                    load = q_ff.pend || start;
                    pipe = 1'b1;
                    nxt_q.pend = 1'b0;
                end
            end
            default: begin
                nxt_q.state = wsrc_pkg::WSRC_IDLE;
            end
        endcase
        // Pick the count for the new cycle and reload the counter.
        hit = wsrc_hit(p.addr, p.mio);
        wsel_reg = q_ff.wcs[p.wsel[1] ? 2'h2 : {1'b0, p.wsel[0]}];
        ws = p.mio ? wsel_reg[`WSRC_MEM_MSB:`WSRC_MEM_LSB]
                   : wsel_reg[`WSRC_IO_MSB:`WSRC_IO_LSB];
        if (hit[2]) begin
            ws = `WSRC_OWN_WS;
        end
        if (load) begin
            nxt_q.state = wsrc_pkg::WSRC_WAIT;
            nxt_q.own = hit[2];
            nxt_q.idx = hit[1:0];
            nxt_q.wr = p.wr;
            nxt_q.drv = hit[2] || p.wsel != `WSRC_WSEL_DIS;
            nxt_q.cnt = 6'(ws * `WSRC_CLK_PER_WS)
                + (pipe ? 6'h00 : `WSRC_CLK_PER_WS);
            nxt_q.doe = hit[2] && !p.wr;
            nxt_q.dout = q_ff.wcs[hit[1:0]];
        end
        // Chip select for own slave cycles and driving acknowledges.
        nxt_q.csel_n = !(nxt_q.own || inta_drive_i);
        // Reset pulse generation.
        if (trig) begin
            nxt_q.rst_cnt = RST_HOLD;
        end else if (q_ff.rst_cnt != 6'h00) begin
            nxt_q.rst_cnt = q_ff.rst_cnt - 6'h01;
        end
        nxt_q.processor_reset_out = p.hw_rst || nxt_q.rst_cnt != 6'h00;
        // A synchronized hardware reset returns the block to its
        // idle slave state.
        if (p.hw_rst) begin
            nxt_q.state = wsrc_pkg::WSRC_IDLE;
            nxt_q.wcs = RESET_Q.wcs;
            nxt_q.own = 1'b0;
            nxt_q.pend = 1'b0;
            nxt_q.drv = 1'b0;
            nxt_q.done_n = 1'b1;
            nxt_q.doe = 1'b0;
            nxt_q.csel_n = 1'b1;
            nxt_q.rst_cnt = 6'h00;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_ff <= RESET_Q;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign cycle_done_out_n_o = q_ff.done_n;
    assign chip_selected_n_o = q_ff.csel_n;
    assign processor_reset_out_o = q_ff.processor_reset_out;
    assign data_o = q_ff.dout;
    assign data_oe_o = q_ff.doe;

    // ========================================================
    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_own_write;
        q_ff.state == wsrc_pkg::WSRC_END && q_ff.own && q_ff.wr
            && !p.rdy_n && !p.hw_rst;
    endsequence

    sequence s_cnt_run;
        q_ff.state == wsrc_pkg::WSRC_WAIT && q_ff.cnt != 6'h00
            && !p.hw_rst;
    endsequence

    property p_rst_load;
        trig && !p.hw_rst |=> processor_reset_out_o
            && q_ff.rst_cnt == RST_HOLD;
    endproperty
    a_rst_load: assert property (p_rst_load)
        else $error("CPU reset pulse did not start.");

    property p_rst_end;
        q_ff.rst_cnt == 6'h01 && !trig && !p.hw_rst
            |=> !processor_reset_out_o;
    endproperty
    a_rst_end: assert property (p_rst_end)
        else $error("CPU reset pulse has wrong length.");

    property p_hw_follow;
        p.hw_rst |=> processor_reset_out_o && cycle_done_out_n_o;
    endproperty
    a_hw_follow: assert property (p_hw_follow)
        else $error("CPU reset does not follow hardware reset.");

    property p_disabled;
        q_ff.state != wsrc_pkg::WSRC_IDLE && !q_ff.drv
            |-> cycle_done_out_n_o;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("Cycle done driven with generator disabled.");

    property p_count_down;
        s_cnt_run |=> q_ff.state == wsrc_pkg::WSRC_WAIT
            && q_ff.cnt == $past(q_ff.cnt) - 6'h01 && cycle_done_out_n_o;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("Wait counter did not step down.");

    property p_done;
        q_ff.state == wsrc_pkg::WSRC_WAIT && q_ff.cnt == 6'h00
            && q_ff.drv && p.rdy_n && !p.hw_rst |=> !cycle_done_out_n_o [*1]
            ##0 q_ff.state == wsrc_pkg::WSRC_END;
    endproperty
    a_done: assert property (p_done)
        else $error("Cycle done missing after count expired.");

    property p_ready_end;
        q_ff.state == wsrc_pkg::WSRC_END && !p.rdy_n
            |=> cycle_done_out_n_o;
    endproperty
    a_ready_end: assert property (p_ready_end)
        else $error("Cycle done held after ready sampled.");

    property p_own_write;
        s_own_write |=> q_ff.wcs[$past(q_ff.idx)] == $past(p.data);
    endproperty
    a_own_write: assert property (p_own_write)
        else $error("Wait register write lost.");

    property p_csel;
        q_ff.own |-> !chip_selected_n_o;
    endproperty
    a_csel: assert property (p_csel)
        else $error("Chip select missing in own slave cycle.");

    property p_inta;
        inta_drive_i && !p.hw_rst |=> !chip_selected_n_o;
    endproperty
    a_inta: assert property (p_inta)
        else $error("Chip select missing in acknowledge cycle.");

    property p_pipe;
        start && q_ff.state == wsrc_pkg::WSRC_WAIT && !p.hw_rst
            |=> q_ff.pend;
    endproperty
    a_pipe: assert property (p_pipe)
        else $error("Pipelined strobe not recorded.");

    property p_stale_ready;
        q_ff.state == wsrc_pkg::WSRC_WAIT && q_ff.cnt == 6'h00
            && p.rdy_n == 1'b0 && !p.hw_rst
            |=> q_ff.state == wsrc_pkg::WSRC_WAIT && cycle_done_out_n_o;
    endproperty
    a_stale_ready: assert property (p_stale_ready)
        else $error("Stale ready ended a new cycle.");

    property p_rst_quiet;
        !p.hw_rst && !trig && q_ff.rst_cnt == 6'h00
            |=> !processor_reset_out_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("CPU reset active without a cause.");

endmodule

// ===== wsrc_map.svh
`ifndef WSRC_MAP_SVH
`define WSRC_MAP_SVH

// ============================================================
// Wait-count register map
`define WSRC_ADDR_WCS0 8'h72
`define WSRC_ADDR_WCS1 8'h73
`define WSRC_ADDR_WCS2 8'h74
`define WSRC_IDX_WCS0 2'h0
`define WSRC_IDX_WCS1 2'h1
`define WSRC_IDX_WCS2 2'h2
`define WSRC_MEM_MSB 7
`define WSRC_MEM_LSB 4
`define WSRC_IO_MSB 3
`define WSRC_IO_LSB 0
`define WSRC_WCS_RESET 8'h00

// ============================================================
// Select codes and timing counts
`define WSRC_WSEL_DIS 2'h3
`define WSRC_CLK_PER_WS 6'h02
`define WSRC_OWN_WS 4'h1
`define WSRC_PROCESSOR_RESET_OUT_CLKS 6'h3e
`define WSRC_HWRST_MIN_CLKS 15

`endif

// ===== wsrc_pkg.sv
package wsrc_pkg;

    // ========================================================
    // Cycle state of the wait-state generator.
    typedef enum logic [1:0] {
        WSRC_IDLE = 2'b00,
        WSRC_WAIT = 2'b01,
        WSRC_END  = 2'b10
    } wsrc_state_t;

    // ========================================================
    // Local-bus pins sampled from outside the clock domain.
    typedef struct packed {
        logic       ads_n;
        logic       rdy_n;
        logic       hw_rst;
        logic [1:0] wsel;
        logic       mio;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } wsrc_pins_t;

    // ========================================================
    // Complete register state of the block.
    typedef struct packed {
        wsrc_pins_t      s1;
        wsrc_pins_t      s2;
        wsrc_pins_t      s3;
        wsrc_pins_t      filt;
        logic            ads_prev;
        wsrc_state_t     state;
        logic [5:0]      cnt;
        logic            drv;
        logic            own;
        logic            wr;
        logic [1:0]      idx;
        logic            pend;
        logic [2:0][7:0] wcs;
        logic [5:0]      rst_cnt;
        logic            done_n;
        logic            csel_n;
        logic            processor_reset_out;
        logic [7:0]      dout;
        logic            doe;
    } wsrc_regs_t;

endpackage

// ===== wsrc_host.sv
`timescale 1ns/10ps
// ============================================================
// Host processor on the local bus. It ends a cycle on the
// cycle-done output, or on its own ready for select code 11.
module wsrc_host (
    // Clock and block outputs.
    input wire logic clk_i,
    input wire logic done_n_i,
    input wire logic csel_n_i,
    input wire logic oe_i,
    input wire logic [7:0] rdata_i,
    // Bus pins.
    output logic ads_n_o,
    output logic ready_n_o,
    output logic [1:0] wsel_o,
    output logic mio_o,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    logic ext = 1'b0;
    logic ext_rdy_n = 1'b1;
    assign ready_n_o = ext ? ext_rdy_n : done_n_i;
    initial begin
        {ads_n_o, wsel_o, mio_o, wr_o} = 5'h1f;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task automatic cycle(input logic [7:0] a, input logic w, input logic m,
        input logic [1:0] ws, input logic [7:0] d, output int lat,
        output logic [7:0] rd, output logic sel);
        lat = 0;
        sel = 1'b1;
        rd = 'x;
        @(posedge clk_i);
        #1;
        {addr_o, wr_o, mio_o, wsel_o, wdata_o} = {a, w, m, ws, d};
        ads_n_o = 1'b0;
        ext = (ws == 2'h3);
        while (done_n_i !== 1'b0 && lat < 40) begin
            @(posedge clk_i);
            #1;
            lat++;
            if (lat == 3) ads_n_o = 1'b1;
            if (csel_n_i === 1'b0) sel = 1'b0;
        end
        if (oe_i === 1'b1) rd = rdata_i;
        ext_rdy_n = 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        ext_rdy_n = 1'b1;
        ext = 1'b0;
        wdata_o = ~d;
        @(posedge clk_i);
    endtask
    // Two reads, the second strobed while the first is still open.
    // Gap counts clocks from the first cycle done to the second.
    task automatic pipe(input logic [7:0] a1, input logic m1,
        input logic [1:0] ws1, input logic [7:0] a2, input logic m2,
        input logic [1:0] ws2, output int gap);
        @(posedge clk_i);
        #1;
        ext = 1'b0;
        {addr_o, wr_o, mio_o, wsel_o} = {a1, 1'b0, m1, ws1};
        ads_n_o = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        ads_n_o = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        {addr_o, mio_o, wsel_o} = {a2, m2, ws2};
        ads_n_o = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        ads_n_o = 1'b1;
        gap = 0;
        while (done_n_i !== 1'b0 && gap < 40) begin
            @(posedge clk_i);
            #1;
            gap++;
        end
        gap = 0;
        while (done_n_i !== 1'b1 && gap < 40) begin
            @(posedge clk_i);
            #1;
            gap++;
        end
        while (done_n_i !== 1'b0 && gap < 80) begin
            @(posedge clk_i);
            #1;
            gap++;
        end
        repeat (12) @(posedge clk_i);
        #1;
        @(posedge clk_i);
    endtask
endmodule

// ===== wait_state_and_reset_ctrl_test.sv
`timescale 1ns/10ps
// ============================================================
// Self-checking bench.
module wait_state_and_reset_ctrl_test;
    localparam logic [5:0] HOLD = 6'h3e;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hw_reset_i = 1'b0;
    logic sw = 1'b0;
    logic sd = 1'b0;
    logic inta = 1'b0;
    logic ads_n, rdy_n, mio, wr, done_n, csel_n, processor_reset_out, oe;
    logic [1:0] wsel;
    logic [7:0] addr, wdata, rdata, rd;
    logic sel;
    logic [7:0] wv [3] = '{8'h31, 8'h52, 8'h40};
    int bad_count = 0;
    int num_checks = 0;
    int lat, base, own, n;
    wsrc_top #(.RST_HOLD(HOLD)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .address_strobe_n_i(ads_n), .ready_n_i(rdy_n),
        .hw_reset_i(hw_reset_i), .wait_select_bit0_i(wsel[0]),
        .wait_select_bit1_i(wsel[1]), .mem_io_i(mio), .write_i(wr),
        .addr_i(addr), .data_i(wdata), .sw_reset_cmd_i(sw),
        .shutdown_detect_i(sd), .inta_drive_i(inta),
        .cycle_done_out_n_o(done_n), .chip_selected_n_o(csel_n),
        .processor_reset_out_o(processor_reset_out), .data_o(rdata), .data_oe_o(oe));
    wsrc_host i_host (.clk_i(clk_i), .done_n_i(done_n), .csel_n_i(csel_n),
        .oe_i(oe), .rdata_i(rdata), .ads_n_o(ads_n), .ready_n_o(rdy_n),
        .wsel_o(wsel), .mio_o(mio), .wr_o(wr), .addr_o(addr),
        .wdata_o(wdata));
    initial forever #2 clk_i = ~clk_i;
    task check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task access(input logic [7:0] a, input logic w, input logic m,
        input logic [1:0] c, input logic [7:0] d);
        i_host.cycle(a, w, m, c, d, lat, rd, sel);
    endtask
    task test_regs;
        for (int i = 0; i < 3; i++) begin
            access(8'h72 + 8'(i), 1'b0, 1'b0, 2'h0, 8'h00);
            check("reset value", 8'h00, rd);
            check("own select", 8'h00, {7'h0, sel});
            access(8'h72 + 8'(i), 1'b1, 1'b0, 2'h0, wv[i]);
            access(8'h72 + 8'(i), 1'b0, 1'b0, 2'h0, 8'h00);
            check("read back", wv[i], rd);
            own = lat;
        end
        $display("test_regs done");
    endtask
    task test_waits;
        access(8'h10, 1'b0, 1'b0, 2'h2, 8'h00);
        base = lat;
        check("foreign select", 8'h01, {7'h0, sel});
        check("own wait", 8'h02, 8'(own - base));
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 2; m++) begin
                access(8'h10, 1'b0, 1'(m), 2'(c), 8'h00);
                n = m ? wv[c][7:4] : wv[c][3:0];
                check("wait clocks", 8'(2 * n), 8'(lat - base));
            end
        end
        access(8'h10, 1'b0, 1'b1, 2'h3, 8'h00);
        check("disabled", 8'd40, 8'(lat));
        access(8'h75, 1'b1, 1'b0, 2'h0, 8'hff);
        check("unmapped select", 8'h01, {7'h0, sel});
        access(8'h72, 1'b0, 1'b0, 2'h0, 8'h00);
        check("unmapped write", wv[0], rd);
        $display("test_waits done");
    endtask
    task test_processor_reset_out;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            #1;
            {sw, sd} = k ? 2'b01 : 2'b10;
            @(posedge clk_i);
            #1;
            {sw, sd} = 2'b00;
            n = 0;
            for (int t = 0; t < 100; t++) begin
                if (processor_reset_out === 1'b1) n++;
                @(posedge clk_i);
                #1;
            end
            check("reset length", 8'(HOLD), 8'(n));
        end
        $display("test_processor_reset_out done");
    endtask
    task test_hw;
        @(posedge clk_i);
        #1;
        hw_reset_i = 1'b1;
        repeat (16) @(posedge clk_i);
        #1;
        check("follow high", 8'h01, {7'h0, processor_reset_out});
        hw_reset_i = 1'b0;
        repeat (8) @(posedge clk_i);
        #1;
        check("follow low", 8'h00, {7'h0, processor_reset_out});
        access(8'h72, 1'b0, 1'b0, 2'h0, 8'h00);
        check("cleared", 8'h00, rd);
        @(posedge clk_i);
        #1;
        inta = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        check("ack select", 8'h00, {7'h0, csel_n});
        inta = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        check("ack release", 8'h01, {7'h0, csel_n});
        $display("test_hw done");
    endtask
    task test_pipe;
        // A pipelined cycle drops the extra wait state of 2 clocks.
        i_host.pipe(8'h10, 1'b1, 2'h1, 8'h10, 1'b1, 2'h0, n);
        check("pipelined wait", 8'(base - 2 + 2 * wv[0][7:4]),
            8'(n));
        $display("test_pipe done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        n = 0;
        repeat (20) begin
            @(posedge clk_i);
            #1;
            if (processor_reset_out !== 1'b0) n++;
        end
        check("idle reset", 8'h00, 8'(n));
        check("idle done", 8'h01, {7'h0, done_n});
        test_regs();
        test_waits();
        test_pipe();
        test_processor_reset_out();
        test_hw();
        finish_test();
    end
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule
